/* File: hdl/eeprom_slave.sv */
// Two-wire serial memory slave with page store and programming timer
`timescale 1ns/1ps
// Function
// RULE_01: Master makes clock, START and STOP; slave never drives the clock.
// RULE_02: Master starts transfers only while both lines are idle high.
// RULE_03: Data stays stable while clock is high; changes mean START/STOP.
// RULE_04: Data falling while clock high is START; restart at control byte.
// RULE_05: Data rising while clock high is STOP; end current operation.
// RULE_06: Master opens each command with START and closes with STOP.
// RULE_07: One clock pulse per bit; data changes only while clock low.
// RULE_08: Write accepts any byte count, keeping only the last sixteen.
// RULE_09: Receiver acknowledges each byte on an extra ninth clock pulse.
// RULE_10: No acknowledge at all while programming runs.
// RULE_11: Acknowledger holds data low for the whole ack clock high.
// RULE_12: Master nack ends read; slave releases data for STOP.
// RULE_13: First byte is control; ack only if top nibble is type code.
// RULE_14: Next three bits select block, the top memory address bits.
// RULE_15: Last control bit: one means read, zero means write.
// RULE_16: Only one such memory may sit on one bus.
// RULE_17: Transmit output held a minimum delay after each clock fall.
// RULE_18: Byte after write control byte loads the address pointer.
// RULE_19: Page writes step only the four low pointer bits.
// RULE_20: STOP after write data starts the programming cycle.
// RULE_21: Busy flag for the whole programming cycle, then normal again.
module eeprom_slave #(
    parameter int WR_CYCLES = eeprom_pkg::WR_CYC
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic WP,
    output logic PROG_BUSY
);
    localparam int AW = eeprom_pkg::ADDR_W;
    localparam int PW = eeprom_pkg::PAGE_W;
    localparam int CW = $clog2(WR_CYCLES + 1);
    localparam int HW = $clog2(eeprom_pkg::HOLD_CYC + 1);
    localparam logic [HW-1:0] HOLD = HW'(eeprom_pkg::HOLD_CYC);
    initial begin
        if (WR_CYCLES < 1) begin
            $error("eeprom_slave: WR_CYCLES must be at least one");
        end
    end
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} st_t;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    // ==========================================================
    // Pin synchronisers and bus condition detection
    logic [2:0] scl_sy_q;
    logic [2:0] sda_sy_q;
    logic [1:0] wp_sy_q;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            scl_sy_q <= 3'h7;
            sda_sy_q <= 3'h7;
            wp_sy_q <= 2'h0;
        end else begin
            scl_sy_q <= {scl_sy_q[1:0], SCL_I};
            sda_sy_q <= {sda_sy_q[1:0], SDA_I};
            wp_sy_q <= {wp_sy_q[0], WP};
        end
    end
    wire scl_s = scl_sy_q[1];
    wire sda_s = sda_sy_q[1];
    wire wp_s = wp_sy_q[1];
    wire scl_rise = scl_s && !scl_sy_q[2];
    wire scl_fall = !scl_s && scl_sy_q[2];
    wire start_c = scl_s && scl_sy_q[2] && sda_sy_q[2] && !sda_s; // see RULE_04
    wire stop_c = scl_s && scl_sy_q[2] && !sda_sy_q[2] && sda_s; // see RULE_05

    // ==========================================================
    // Protocol state
    st_t state_q;
    eeprom_pkg::kind_t kind_q;
    logic [3:0] bitcnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [eeprom_pkg::BLK_W-1:0] blk_q;
    logic rw_q;
    logic mack_q;
    logic [AW-1:0] addr_q;
    logic next_low_q;
    logic sda_low_q;
    logic [HW-1:0] hold_q;
    logic wrote_q;
    logic pend_q;
    logic busy_q;
    logic [CW-1:0] busy_cnt_q;
    logic [7:0] mem [1 << AW];
    logic [7:0] page_q [1 << PW];
    logic [(1 << PW)-1:0] pvalid_q;

    wire byte_end = (state_q == ST_RX) && scl_fall
        && (bitcnt_q == eeprom_pkg::BYTE_BITS);
    wire code_ok = shift_q[7:4] == eeprom_pkg::TYPE_CODE;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [PW+7:0] buf_out;
    wire data_push = byte_end && (kind_q == eeprom_pkg::K_DATA)
        && !busy_q && buf_in_ready;
    // Ack decision: silent while busy, wrong code, or buffer full
    wire kind_ok = (kind_q == eeprom_pkg::K_CTRL) ? code_ok // see RULE_13
        : (kind_q == eeprom_pkg::K_DATA) ? buf_in_ready : 1'b1;
    wire ack_ok = !busy_q && kind_ok; // see RULE_10
    wire [7:0] rd_byte = mem[addr_q];
    wire [2:0] tx_idx = 3'(4'h7 - bitcnt_q);

    pair_buffer #(
        .WIDTH(PW + 8),
        .DEPTH(eeprom_pkg::BUF_DEPTH)
    ) u_buf (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .in_valid(data_push),
        .in_ready(buf_in_ready),
        .in_data({addr_q[PW-1:0], shift_q}),
        .out_valid(buf_out_valid),
        .out_ready(!busy_q),
        .out_data(buf_out)
    );

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            kind_q <= eeprom_pkg::K_CTRL;
            bitcnt_q <= '0;
            shift_q <= '0;
            tx_q <= '0;
            blk_q <= '0;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            addr_q <= '0;
            next_low_q <= 1'b0;
            wrote_q <= 1'b0;
        end else if (start_c) begin
            state_q <= ST_RX; // see RULE_04
            kind_q <= eeprom_pkg::K_CTRL;
            bitcnt_q <= '0;
            next_low_q <= 1'b0;
            wrote_q <= 1'b0;
        end else if (stop_c) begin
            state_q <= ST_IDLE; // see RULE_05
            next_low_q <= 1'b0;
            wrote_q <= 1'b0;
        end else if (scl_rise) begin
            if (state_q == ST_RX) begin
                shift_q <= {shift_q[6:0], sda_s}; // see RULE_07
                bitcnt_q <= bitcnt_q + 1'b1;
            end else if (state_q == ST_TX) begin
                bitcnt_q <= bitcnt_q + 1'b1;
            end else if (state_q == ST_MACK) begin
                mack_q <= !sda_s;
            end
        end else if (scl_fall) begin
            unique case (state_q)
                ST_IDLE: begin
                    next_low_q <= 1'b0;
                end
                ST_RX: begin
                    if (bitcnt_q == eeprom_pkg::BYTE_BITS) begin
                        if (!ack_ok) begin
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_ACK;
                            next_low_q <= 1'b1; // see RULE_09, RULE_11
                            unique case (kind_q)
                                eeprom_pkg::K_CTRL: begin
                                    blk_q <= shift_q[3:1]; // see RULE_14
                                    rw_q <= shift_q[0]; // see RULE_15
                                    kind_q <= eeprom_pkg::K_WADDR;
                                end
                                eeprom_pkg::K_WADDR: begin
                                    addr_q <= {blk_q, shift_q}; // see RULE_18
                                    kind_q <= eeprom_pkg::K_DATA;
                                end
                                eeprom_pkg::K_DATA: begin
                                    // see RULE_08, RULE_19
                                    addr_q[PW-1:0] <= addr_q[PW-1:0] + 1'b1;
                                    wrote_q <= 1'b1;
                                end
                                default: begin
                                    state_q <= ST_IDLE;
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    bitcnt_q <= '0;
                    if (rw_q) begin
                        state_q <= ST_TX;
                        tx_q <= rd_byte;
                        addr_q[AW-1:8] <= blk_q;
                        next_low_q <= !rd_byte[7];
                    end else begin
                        state_q <= ST_RX;
                        next_low_q <= 1'b0;
                    end
                end
                ST_TX: begin
                    if (bitcnt_q == eeprom_pkg::BYTE_BITS) begin
                        state_q <= ST_MACK;
                        next_low_q <= 1'b0;
                        addr_q <= addr_q + 1'b1;
                    end else begin
                        next_low_q <= !tx_q[tx_idx];
                    end
                end
                ST_MACK: begin
                    bitcnt_q <= '0;
                    if (mack_q) begin
                        state_q <= ST_TX;
                        tx_q <= rd_byte;
                        next_low_q <= !rd_byte[7];
                    end else begin
                        state_q <= ST_IDLE; // see RULE_12
                        next_low_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Output hold after each falling clock edge
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hold_q <= '0;
            sda_low_q <= 1'b0;
        end else if (start_c || stop_c) begin
            hold_q <= '0;
            sda_low_q <= 1'b0;
        end else if (scl_fall) begin
            hold_q <= HOLD; // see RULE_17
        end else if (hold_q != '0) begin
            hold_q <= hold_q - 1'b1;
            if (hold_q == HW'(1)) begin
                sda_low_q <= next_low_q && !busy_q; // see RULE_03, RULE_17
            end
        end
    end
    assign SDA_O = 1'b0;
    assign SDA_OE = sda_low_q; // see RULE_11

    // ==========================================================
    // Page store and programming cycle
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pvalid_q <= '0;
            pend_q <= 1'b0;
            busy_q <= 1'b0;
            busy_cnt_q <= '0;
        end else begin
            if (buf_out_valid && !busy_q) begin
                page_q[buf_out[PW+7:8]] <= buf_out[7:0]; // see RULE_08
                pvalid_q[buf_out[PW+7:8]] <= 1'b1;
            end
            if (stop_c && wrote_q) begin
                pend_q <= 1'b1; // see RULE_20
            end else if (pend_q && !buf_out_valid) begin
                pend_q <= 1'b0;
                pvalid_q <= '0;
                busy_q <= !wp_s; // see RULE_21
                busy_cnt_q <= CW'(WR_CYCLES);
            end else if (busy_q) begin
                busy_cnt_q <= busy_cnt_q - 1'b1;
                busy_q <= busy_cnt_q != CW'(1); // see RULE_21
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (pend_q && !buf_out_valid && !wp_s) begin
            for (int i = 0; i < (1 << PW); i++) begin
                if (pvalid_q[i]) begin
                    mem[{addr_q[AW-1:PW], PW'(i)}] <= page_q[i];
                end
            end
        end
    end
    assign PROG_BUSY = busy_q;

    // ==========================================================
    // Checks
    sequence s_ctrl_end;
        byte_end && kind_q == eeprom_pkg::K_CTRL;
    endsequence
    sequence s_ctrl_ok;
        s_ctrl_end ##0 ack_ok;
    endsequence

    start_restart_a: assert property ( // see RULE_04
        start_c |=> state_q == ST_RX && bitcnt_q == 4'h0
            && kind_q == eeprom_pkg::K_CTRL)
        else $error("START did not restart control byte");
    stop_idle_a: assert property ( // see RULE_05
        stop_c |=> state_q == ST_IDLE && !SDA_OE)
        else $error("STOP did not end operation");
    busy_silent_a: assert property ( // see RULE_10
        busy_q && $past(busy_q) |-> !SDA_OE)
        else $error("Data pulled low while programming");
    out_hold_a: assert property ( // see RULE_17
        $past(hold_q) != HW'(1) && !$past(start_c || stop_c)
            |-> $stable(sda_low_q))
        else $error("Data output changed outside hold expiry");
    fall_hold_a: assert property ( // see RULE_17
        scl_fall && !start_c && !stop_c |=> $stable(SDA_OE)[*8])
        else $error("Data output moved too soon after clock fall");
    code_mismatch_a: assert property ( // see RULE_13
        s_ctrl_end ##0 !code_ok |=> state_q == ST_IDLE)
        else $error("Foreign control byte not ignored");
    block_sel_a: assert property ( // see RULE_14
        s_ctrl_ok |=> blk_q == $past(shift_q[3:1]))
        else $error("Block select not captured");
    dir_bit_a: assert property ( // see RULE_15
        s_ctrl_ok |=> rw_q == $past(shift_q[0]) && state_q == ST_ACK)
        else $error("Direction bit not captured");
    nack_release_a: assert property ( // see RULE_12
        state_q == ST_MACK && scl_fall && !mack_q && !start_c && !stop_c
            |=> state_q == ST_IDLE ##[1:40] !SDA_OE)
        else $error("Slave held data after master nack");
    page_wrap_a: assert property ( // see RULE_19
        data_push |=> $stable(addr_q[AW-1:PW])
            && addr_q[PW-1:0] == $past(addr_q[PW-1:0]) + 1'b1)
        else $error("Page pointer did not wrap in low bits");
    prog_start_a: assert property ( // see RULE_20
        stop_c && wrote_q |=> pend_q ##[1:3] (busy_q || wp_s))
        else $error("STOP after data did not start programming");
endmodule

/* File: hdl/eeprom_pkg.sv */
// Shared constants for the two-wire serial memory slave
package eeprom_pkg;
    // Device type code: arbitrary value, not tied to any real part
    localparam logic [3:0] TYPE_CODE = 4'h5;
    localparam int ADDR_W = 11;
    localparam int PAGE_W = 4;
    localparam int BLK_W = 3;
    localparam int CLK_PERIOD_NS = 8;
    // Least hold of the data output after a falling clock edge
    localparam int HOLD_NS = 300;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Self-timed programming cycle
    localparam int WR_TIME_US = 10000;
    localparam int WR_CYC = WR_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int BUF_DEPTH = 2;
    typedef enum logic [1:0] {K_CTRL, K_WADDR, K_DATA} kind_t;
endpackage

/* File: hdl/pair_buffer.sv */
// Small valid/ready buffer between byte receiver and page store
`timescale 1ns/1ps
module pair_buffer #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
            $error("pair_buffer: DEPTH must be a power of two >= 2");
        end
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0] wr_q;
    logic [PW:0] rd_q;
    wire full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[rd_q[PW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

/* File: tb/bus_master.sv */
// Behavioural two-wire bus master that drives the serial clock
`timescale 1ns/1ps
module bus_master #(
    parameter int Q = 25
) (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_low
);
    // Idle bus: both lines released high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_q(input int n);
        repeat (n * Q) @(posedge clk);
    endtask

    // START from idle or as a repeated START; clock is left low
    task automatic start();
        wait_q(1);
        sda_low <= 1'b0;
        wait_q(1);
        scl <= 1'b1;
        wait_q(2);
        sda_low <= 1'b1;
        wait_q(2);
        scl <= 1'b0;
    endtask

    task automatic stop();
        wait_q(1);
        sda_low <= 1'b1;
        wait_q(1);
        scl <= 1'b1;
        wait_q(2);
        sda_low <= 1'b0;
        wait_q(4);
    endtask

    // One clock pulse per bit; data moves only while the clock is low
    task automatic bit_xfer(input logic b, output logic seen);
        wait_q(1);
        sda_low <= ~b;
        wait_q(1);
        scl <= 1'b1;
        wait_q(1);
        seen = sda_in;
        wait_q(1);
        scl <= 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, s);
        acked = (s === 1'b0);
    endtask

    task automatic recv_byte(input logic give_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            d[i] = s;
        end
        // Withholding the ack ends the read
        bit_xfer(~give_ack, s);
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the two-wire serial memory slave
`timescale 1ns/1ps
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin \
    fails++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb_top;
    localparam int WR_T = 3000;
    localparam logic [3:0] TC = eeprom_pkg::TYPE_CODE;
    logic ref_clk, rst_n, wp, scl, m_low, sda_w, sda_o, sda_oe, busy;
    logic prev_busy;
    int busy_len;
    int fails;
    int tests_run;

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Open-drain data wire with pull-up; one slave only
    assign sda_w = ~(m_low | (sda_oe & ~sda_o));

    bus_master m (.clk(ref_clk), .sda_in(sda_w), .scl(scl), .sda_low(m_low));
    eeprom_slave #(.WR_CYCLES(WR_T)) DUT (
        .REF_CLK(ref_clk), .RST_N(rst_n), .SCL_I(scl), .SDA_I(sda_w),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .WP(wp), .PROG_BUSY(busy));

    // Length of the latest programming pulse
    always @(posedge ref_clk) begin
        prev_busy <= busy;
        if (busy === 1'b1)
            busy_len <= (prev_busy === 1'b1) ? busy_len + 1 : 1;
    end

    function automatic logic [7:0] ctrl(input logic [2:0] blk, input logic rd);
        return {TC, blk, rd};
    endfunction

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20000) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(busy, 1'b0, "programming never ended")
    endtask

    // Sets the pointer, then reads one byte ended by a master nack
    task automatic read_one(input logic [2:0] blk, input logic [7:0] a,
                            input logic [7:0] exp);
        logic k;
        logic [7:0] d;
        m.start();
        m.send_byte(ctrl(blk, 1'b0), k);
        m.send_byte(a, k);
        m.start();
        m.send_byte(ctrl(blk, 1'b1), k);
        `CHK(k, 1'b1, "read control not acked")
        m.recv_byte(1'b0, d);
        `CHK(d, exp, "read data")
        `CHK(sda_oe, 1'b0, "data not released after nack")
        m.stop();
    endtask

    task automatic t_write_busy();
        logic k;
        m.start();
        m.send_byte(ctrl(3'h3, 1'b0), k);
        `CHK(k, 1'b1, "write control not acked")
        m.send_byte(8'h25, k);
        `CHK(k, 1'b1, "word address not acked")
        m.send_byte(8'h3c, k);
        `CHK(k, 1'b1, "data not acked")
        m.stop();
        repeat (4) @(posedge ref_clk);
        `CHK(busy, 1'b1, "no programming after stop")
        m.start();
        m.send_byte(ctrl(3'h3, 1'b0), k);
        `CHK(k, 1'b0, "acked while programming")
        m.stop();
        wait_idle();
        `CHK(busy_len, WR_T, "programming length")
        read_one(3'h3, 8'h25, 8'h3c);
        $display("test write_busy done");
    endtask

    task automatic t_type_codes();
        logic k;
        for (int c = 0; c < 16; c++) begin
            m.start();
            m.send_byte({c[3:0], 3'h1, 1'b0}, k);
            `CHK(k, (c[3:0] == TC), "type code decode")
            m.stop();
        end
        $display("test type_codes done");
    endtask

    task automatic t_page();
        logic k;
        logic [7:0] d;
        int i0;
        m.start();
        m.send_byte(ctrl(3'h5, 1'b0), k);
        m.send_byte(8'h9e, k);
        for (int i = 0; i < 18; i++) begin
            m.send_byte(8'h40 + i[7:0], k);
            `CHK(k, 1'b1, "page byte not acked")
        end
        m.stop();
        wait_idle();
        m.start();
        m.send_byte(ctrl(3'h5, 1'b0), k);
        m.send_byte(8'h90, k);
        m.start();
        m.send_byte(ctrl(3'h5, 1'b1), k);
        for (int s = 0; s < 16; s++) begin
            m.recv_byte(s != 15, d);
            i0 = (s + 2) % 16;
            if (i0 < 2)
                i0 += 16;
            `CHK(d, 8'h40 + i0[7:0], "page slot")
        end
        m.stop();
        $display("test page done");
    endtask

    task automatic t_abort();
        logic k;
        logic s;
        m.start();
        repeat (4) m.bit_xfer(1'b0, s);
        m.start();
        m.send_byte(ctrl(3'h2, 1'b0), k);
        `CHK(k, 1'b1, "no restart after mid-byte start")
        m.bit_xfer(1'b1, s);
        m.bit_xfer(1'b0, s);
        m.stop();
        `CHK(busy, 1'b0, "stop without data programmed")
        m.start();
        m.send_byte(ctrl(3'h2, 1'b0), k);
        `CHK(k, 1'b1, "not idle after stop")
        m.stop();
        $display("test abort done");
    endtask

    task automatic t_wp();
        logic k;
        wp <= 1'b1;
        m.start();
        m.send_byte(ctrl(3'h3, 1'b0), k);
        m.send_byte(8'h25, k);
        m.send_byte(8'hc5, k);
        `CHK(k, 1'b1, "protected data not acked")
        m.stop();
        repeat (20) @(posedge ref_clk);
        `CHK(busy, 1'b0, "programming while protected")
        wp <= 1'b0;
        read_one(3'h3, 8'h25, 8'h3c);
        $display("test write_protect done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        wp = 1'b0;
        fails = 0;
        tests_run = 0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_write_busy();
        t_type_codes();
        t_abort();
        t_page();
        t_wp();
        tally_and_finish();
    end

    // Tests need roughly 81000 cycles
    initial begin
        repeat (95000) @(posedge ref_clk);
        fails++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
